// ===== design/asp_pkg.sv
// Shared constants, types and helpers of the analog sample packer.
// Assumes a single 100 MHz clock domain for every user of this package.
package asp_pkg;

    // Geometry
    localparam int NCH      = 8;
    localparam int ACC_BITS = 80;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_MAXLEN = 6'h04;
    localparam logic [5:0] OFS_NSCHED = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_DESC   = 6'h20;

    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_NCH_LSB   = 4;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ERR_BIT   = 1;
    localparam int STAT_DONE_LSB  = 16;
    localparam int FACTOR_LSB     = 24;
    localparam int LENGTH_LSB     = 2;
    localparam int MODE_LSB       = 0;

    // Values after reset
    localparam logic [2:0]  RST_NCH_M1 = 3'h0;
    localparam logic [15:0] RST_MAXLEN = 16'hffff;
    localparam logic [15:0] RST_NSCHED = 16'h0001;
    localparam logic [31:0] RST_DESC   = 32'h00000030;

    // Packing mode codes
    localparam logic [1:0] MODE_PACKED = 2'h0;
    localparam logic [1:0] MODE_LSBPAD = 2'h1;
    localparam logic [1:0] MODE_RSVD   = 2'h2;
    localparam logic [1:0] MODE_MSBPAD = 2'h3;

    // Bit counts
    localparam logic [6:0] WORD_BITS = 7'h10;
    localparam logic [6:0] DESC_BITS = 7'h20;
    localparam logic [6:0] FULL_BITS = 7'h40;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_CALC  = 5'h02,
        S_DESC  = 5'h04,
        S_SAMP  = 5'h08,
        S_FLUSH = 5'h10
    } asp_state_type;

    // Bit run handed to the word builder
    typedef struct packed {
        logic [63:0] bits;
        logic [6:0]  nbits;
    } asp_chunk_type;

    // Word leaving toward the recorder
    typedef struct packed {
        logic [15:0] data;
        logic        last;
    } asp_word_type;

    // Length code zero stands for 64-bit samples
    function automatic logic [6:0] asp_width(input logic [5:0] code);
        return (code == 6'h00) ? FULL_BITS : {1'b0, code};
    endfunction

    // Round a width up to whole 16-bit words
    function automatic logic [6:0] asp_align16(input logic [6:0] w);
        return 7'(w + 7'h0f) & 7'h70;
    endfunction

    // Simultaneous sample index is a multiple of 2**k
    function automatic logic asp_due(input logic [15:0] step, input logic [3:0] k);
        return (step & 16'((17'h1 << k) - 17'h1)) == 16'h0000;
    endfunction

endpackage

// ===== design/asp_sched_sel.sv
// Picks the next subchannel due in the current simultaneous sample.
// Assumes a descriptor table held by the caller, entries in ascending order.
`timescale 1ns/1ns
`default_nettype none

module asp_sched_sel (
    input  wire logic [15:0]                step,
    input  wire logic [3:0]                 from,
    input  wire logic [3:0]                 nch,
    input  wire logic [asp_pkg::NCH-1:0][3:0] factors,
    output logic                            hit,
    output logic [2:0]                      chan
);
    import asp_pkg::*;

    // Scan downward so the lowest due entry wins
    always_comb begin
        hit  = 1'b0;
        chan = 3'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (4'(i) >= from && 4'(i) < nch && asp_due(step, factors[i])) begin
                hit  = 1'b1;
                chan = 3'(i);
            end
        end
    end

endmodule // asp_sched_sel

`default_nettype wire

// ===== design/asp_bit_packer.sv
// Little-endian bit accumulator that cuts runs of bits into 16-bit words.
// Assumes the caller never pushes while it holds flush high.
`timescale 1ns/1ns
`default_nettype none

module asp_bit_packer (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  in_valid,
    input  wire asp_pkg::asp_chunk_type in_chunk,
    output logic                       in_ready,
    input  wire logic                  flush,
    output logic                       out_valid,
    output asp_pkg::asp_word_type      out_word,
    input  wire logic                  out_ready,
    output logic                       idle
);
    import asp_pkg::*;

    typedef struct packed {
        logic [ACC_BITS-1:0] acc;
        logic [6:0]          cnt;
    } asp_pk_state_type;

    asp_pk_state_type r;
    asp_pk_state_type n;

    // Outside flush, words leave only above 16 bits held, so the final one can carry last
    always_comb begin
        n         = r;
        in_ready  = (r.cnt <= WORD_BITS);
        out_valid = (r.cnt > WORD_BITS) || (flush && r.cnt != 7'h00);
        if (in_valid && in_ready) begin
            n.acc = r.acc | (ACC_BITS'(in_chunk.bits) << r.cnt);
            n.cnt = r.cnt + in_chunk.nbits;
        end else if (out_valid && out_ready) begin
            n.acc = r.acc >> WORD_BITS;
            n.cnt = (r.cnt > WORD_BITS) ? 7'(r.cnt - WORD_BITS) : 7'h00;
        end
    end

    // Upper bits of a short final word are already zero fill
    assign out_word = '{data: r.acc[15:0], last: flush && r.cnt <= WORD_BITS};
    assign idle     = (r.cnt == 7'h00);

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking pk_cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fill_zero:
        assert property ((r.acc >> r.cnt) == '0) else $error("bits above count not zero");
    a_word_last:
        assert property (out_valid && out_ready && out_word.last |=> idle)
        else $error("last word left bits behind");

endmodule // asp_bit_packer

`default_nettype wire

// ===== design/asp_packer_top.sv
// Analog packet body builder: register slave, schedule walk, sample framing.
// Assumes an Avalon-MM master, sample sources and recorder all on clk.
`timescale 1ns/1ns
`default_nettype none

module asp_packer_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [2:0]       smp_chan,
    output logic             smp_ready,
    input  wire logic        smp_valid,
    input  wire logic [63:0] smp_data,
    output logic [15:0]      pkt_data,
    output logic             pkt_valid,
    output logic             pkt_last,
    input  wire logic        pkt_ready,
    output logic             busy
);
    import asp_pkg::*;

    typedef struct packed {
        asp_state_type            st;
        logic                     ack;
        logic [31:0]              rdata;
        logic [2:0]               nch_m1;
        logic [15:0]              maxlen;
        logic [15:0]              nsched;
        logic [NCH-1:0][31:0]     desc;
        logic                     err;
        logic [3:0]               c;
        logic                     pass;
        logic [15:0]              s;
        logic [3:0]               maxk;
        logic [31:0]              sbits;
        logic [31:0]              used;
        logic [15:0]              done;
    } asp_top_state_type;

    asp_top_state_type    r;
    asp_top_state_type    n;
    logic                 rst_meta, rst_n;
    logic [3:0]           nch;
    logic [1:0]           mode;
    logic [NCH-1:0][3:0]  factors;
    logic                 sel_hit, more, smp_take;
    logic [2:0]           sel_chan;
    logic [31:0]          cdesc, sdesc, next_words, rd_mux;
    logic [6:0]           cw, sw, sa;
    logic [63:0]          raw;
    logic [15:0]          max_d;
    logic                 pk_in_valid, pk_in_ready, pk_flush, pk_idle;
    asp_chunk_type        chunk;
    asp_word_type         pk_word;
    // Reset released through two flops, asserted at once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Descriptor field decode
    assign nch  = 4'({1'b0, r.nch_m1} + 4'h1);
    assign mode = r.desc[0][MODE_LSB +: 2];
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            factors[i] = r.desc[i][FACTOR_LSB +: 4];
        end
    end
    assign cdesc = r.desc[r.c[2:0]];
    assign sdesc = r.desc[sel_chan];
    assign cw    = asp_width(cdesc[LENGTH_LSB +: 6]);
    assign sw    = asp_width(sdesc[LENGTH_LSB +: 6]);
    assign sa    = asp_align16(sw);
    assign max_d = 16'(17'h1 << r.maxk);
    // Sample masked to its width so padding stays zero
    assign raw = (sw == FULL_BITS) ? smp_data : (smp_data & ((64'h1 << sw) - 64'h1));
    asp_sched_sel u_sel (
        .step    (r.s),
        .from    (r.c),
        .nch     (nch),
        .factors (factors),
        .hit     (sel_hit),
        .chan    (sel_chan)
    );
    // Schedule fit: descriptor words plus rounded body words
    assign next_words = 32'({nch, 1'b0}) + ((r.used + r.sbits + 32'h0000000f) >> 4);
    assign more = (r.nsched == 16'h0000 || 16'(r.done + 16'h1) < r.nsched)
                  && (next_words <= 32'(r.maxlen));
    // Register read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (avs_address[5]) begin
            rd_mux = r.desc[avs_address[4:2]];
        end else begin
            case (avs_address)
                OFS_CTRL:   rd_mux = 32'({r.nch_m1, 4'h0});
                OFS_MAXLEN: rd_mux = 32'(r.maxlen);
                OFS_NSCHED: rd_mux = 32'(r.nsched);
                OFS_STATUS: rd_mux = {r.done, 14'h0000, r.err, r.st != S_IDLE};
                default:    rd_mux = 32'h00000000;
            endcase
        end
    end
    // Bus slave, packer feed and the frame walk
    always_comb begin
        n           = r;
        pk_in_valid = 1'b0;
        pk_flush    = 1'b0;
        smp_ready   = 1'b0;
        chunk       = '{bits: 64'(cdesc), nbits: DESC_BITS};
        n.ack       = (avs_read || avs_write) && !r.ack;
        if (avs_read && !r.ack) begin
            n.rdata = rd_mux;
        end
        // Writes land on the acknowledging edge; config locked while busy
        if (avs_write && r.ack && r.st == S_IDLE) begin
            if (avs_address[5]) begin
                n.desc[avs_address[4:2]] = avs_writedata;
            end else if (avs_address == OFS_CTRL) begin
                n.nch_m1 = avs_writedata[CTRL_NCH_LSB +: 3];
            end else if (avs_address == OFS_MAXLEN) begin
                n.maxlen = avs_writedata[15:0];
            end else if (avs_address == OFS_NSCHED) begin
                n.nsched = avs_writedata[15:0];
            end
        end
        case (r.st)
            S_IDLE: begin
                if (avs_write && r.ack && avs_address == OFS_CTRL
                    && avs_writedata[CTRL_START_BIT]) begin
                    n.err = (mode == MODE_RSVD);
                    if (mode != MODE_RSVD) begin
                        n.st    = S_CALC;
                        n.c     = 4'h0;
                        n.pass  = 1'b0;
                        n.maxk  = 4'h0;
                        n.sbits = 32'h00000000;
                        n.used  = 32'h00000000;
                        n.done  = 16'h0000;
                    end
                end
            end
            // Two passes: slowest factor, then bits per schedule
            S_CALC: begin
                if (!r.pass) begin
                    if (factors[r.c[2:0]] > r.maxk) begin
                        n.maxk = factors[r.c[2:0]];
                    end
                end else begin
                    n.sbits = r.sbits + (32'((mode == MODE_PACKED) ? cw : asp_align16(cw))
                              << (r.maxk - factors[r.c[2:0]]));
                end
                if (r.c == nch - 4'h1) begin
                    n.c    = 4'h0;
                    n.pass = 1'b1;
                    n.st   = r.pass ? S_DESC : S_CALC;
                end else begin
                    n.c = 4'(r.c + 4'h1);
                end
            end
            S_DESC: begin
                pk_in_valid = 1'b1;
                if (pk_in_ready) begin
                    if (r.c == nch - 4'h1) begin
                        n.st = S_SAMP;
                        n.c  = 4'h0;
                        n.s  = 16'h0001;
                    end else begin
                        n.c = 4'(r.c + 4'h1);
                    end
                end
            end
            S_SAMP: begin
                case (mode)
                    MODE_PACKED: chunk = '{bits: raw, nbits: sw};
                    MODE_LSBPAD: chunk = '{bits: raw << (sa - sw), nbits: sa};
                    default:     chunk = '{bits: raw, nbits: sa};
                endcase
                if (sel_hit) begin
                    smp_ready   = pk_in_ready;
                    pk_in_valid = smp_valid;
                    if (smp_valid && pk_in_ready) begin
                        n.used = r.used + 32'(chunk.nbits);
                        n.c    = 4'({1'b0, sel_chan} + 4'h1);
                    end
                end else if (r.s == max_d) begin
                    n.done = 16'(r.done + 16'h1);
                    n.c    = 4'h0;
                    n.s    = 16'h0001;
                    n.st   = more ? S_SAMP : S_FLUSH;
                end else begin
                    n.s = 16'(r.s + 16'h1);
                    n.c = 4'h0;
                end
            end
            S_FLUSH: begin
                pk_flush = 1'b1;
                if (pk_idle) begin
                    n.st = S_IDLE;
                end
            end
            default: n.st = S_IDLE;
        endcase
    end
    asp_bit_packer u_pk (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (pk_in_valid),
        .in_chunk  (chunk),
        .in_ready  (pk_in_ready),
        .flush     (pk_flush),
        .out_valid (pkt_valid),
        .out_word  (pk_word),
        .out_ready (pkt_ready),
        .idle      (pk_idle)
    );
    assign smp_take        = smp_ready && smp_valid;
    assign smp_chan        = sel_chan;
    assign pkt_data        = pk_word.data;
    assign pkt_last        = pk_word.last;
    assign busy            = (r.st != S_IDLE);
    assign avs_readdata    = r.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !r.ack;
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0;
            r.st     <= S_IDLE;
            r.nch_m1 <= RST_NCH_M1;
            r.maxlen <= RST_MAXLEN;
            r.nsched <= RST_NSCHED;
            r.desc   <= {NCH{RST_DESC}};
        end else begin
            r <= n;
        end
    end
    // Previous take, for ordering checks only
    logic        prv_ok;
    logic [15:0] prv_s;
    logic [2:0]  prv_ch;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prv_ok <= 1'b0;
            prv_s  <= 16'h0000;
            prv_ch <= 3'h0;
        end else if (smp_take) begin
            prv_ok <= 1'b1;
            prv_s  <= r.s;
            prv_ch <= sel_chan;
        end else if (!sel_hit || r.st != S_SAMP) begin
            prv_ok <= 1'b0; // Order restarts with each simultaneous sample
        end
    end
    default clocking top_cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_samp_due:
        assert property (smp_ready |-> asp_due(r.s, factors[sel_chan]) && sel_chan < nch)
        else $error("subchannel taken off its rate");
    a_samp_order:
        assert property (smp_take && prv_ok && prv_s == r.s |-> sel_chan > prv_ch)
        else $error("subchannel order not ascending");
    a_sched_bound:
        assert property (r.st == S_SAMP |-> r.s != 16'h0000 && r.s <= max_d)
        else $error("simultaneous sample index out of range");
    a_sched_count:
        assert property (r.st == S_SAMP && !sel_hit && r.s == max_d |=> r.done == $past(r.done) + 16'h1)
        else $error("schedule end not counted");
    a_one_sched:
        assert property (r.st == S_FLUSH |-> r.done != 16'h0000)
        else $error("packet closed without a schedule");
    a_len_fit:
        assert property (r.st == S_FLUSH && r.done > 16'h0001 |->
                         32'({nch, 1'b0}) + ((r.used + 32'h0000000f) >> 4) <= 32'(r.maxlen))
        else $error("packet length exceeded");
    a_desc_half:
        assert property (pk_in_valid && r.st == S_DESC |-> chunk.nbits == DESC_BITS
                         && chunk.bits == 64'(r.desc[r.c[2:0]]))
        else $error("descriptor word malformed");
    a_msb_pad:
        assert property (smp_take && mode == MODE_MSBPAD |-> (chunk.bits >> sw) == 64'h0)
        else $error("MSB pad bits not zero");
    a_lsb_pad:
        assert property (smp_take && mode == MODE_LSBPAD |->
                         (chunk.bits & ((64'h1 << (sa - sw)) - 64'h1)) == 64'h0
                         && (chunk.bits >> (sa - sw)) == raw)
        else $error("LSB padded sample not left-justified");
    a_unpk_align:
        assert property (smp_take && mode != MODE_PACKED |->
                         chunk.nbits[3:0] == 4'h0 && chunk.nbits - sw < WORD_BITS)
        else $error("unpacked sample not word aligned");
    a_pack_raw:
        assert property (smp_take && mode == MODE_PACKED |-> chunk.nbits == sw)
        else $error("packed sample padded");
    a_no_rsvd:
        assert property (r.st != S_IDLE |-> mode != MODE_RSVD)
        else $error("reserved mode in use");
    c_two_sched:  cover property (r.st == S_FLUSH && r.done == 16'h0002);
    c_packed_end: cover property (pkt_valid && pkt_last && mode == MODE_PACKED);
    c_lsb_take:   cover property (smp_take && mode == MODE_LSBPAD && r.s > 16'h0001);
    c_rsvd_err:   cover property (r.err);

endmodule // asp_packer_top

`default_nettype wire

// ===== testbench/asp_rec_model.sv
// Recorder model: takes packet words off the stream and keeps them in order.
// Assumes the packer's stream runs on the bench clock.
`timescale 1ns/1ns
`default_nettype none

module asp_rec_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [15:0] pkt_data,
    input  wire logic        pkt_valid,
    input  wire logic        pkt_last,
    output logic             pkt_ready
);
    logic [16:0] words[$];
    logic [1:0]  cnt;

    initial begin
        cnt = 2'h0;
        pkt_ready = 1'b0;
    end

    // Slow mode accepts one cycle in three, to hold the packer in stall
    always @(posedge clk) begin
        cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
        pkt_ready <= !slow || (cnt == 2'h2);
        if (pkt_valid && pkt_ready) begin
            words.push_back({pkt_last, pkt_data});
        end
    end
endmodule // asp_rec_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench of the analog sample packer: registers, schedules, framing.
// Assumes the recorder model and a sample source that names channel and take count.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import asp_pkg::*;
    logic        clk, resetn, slow, smp_valid, avs_read, avs_write;
    logic        avs_waitrequest, smp_ready, pkt_valid, pkt_last, pkt_ready, busy;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0]  smp_chan;
    logic [63:0] smp_data;
    logic [15:0] pkt_data;
    logic [31:0] dsc[NCH];
    logic        eb[$];
    int          err_count = 0, checked = 0, ntk = 0, cyc = 0;

    asp_packer_top u_asp_packer_top (.clk(clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .smp_chan(smp_chan),
        .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_data(smp_data),
        .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_last(pkt_last),
        .pkt_ready(pkt_ready), .busy(busy));
    asp_rec_model u_rec (.clk(clk), .slow(slow), .pkt_data(pkt_data),
        .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready));

    // Source value carries channel and take count, junk above bit 10, so above every width short of 64
    assign smp_data = {53'h1f0f0f0f0f0f0f, smp_chan, ntk[7:0]};
    always @(posedge clk) begin
        cyc <= cyc + 1;
        smp_valid <= (cyc % 4) != 0;   // Hold-off one cycle in four
        if (smp_ready && smp_valid) begin
            ntk <= ntk + 1;
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tmo(input string nm);
        err_count++;
        $display("ERROR %s expected done seen timeout", nm);
        test_done();
    endtask

    // Avalon transfer; the request holds until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 20) tmo("waitrequest");
    endtask

    function automatic int wid(input int i);
        return (dsc[i][7:2] == 6'h00) ? 64 : int'(dsc[i][7:2]);
    endfunction

    task automatic put(input logic [63:0] v, input int n);
        for (int j = 0; j < n; j++) eb.push_back(v[j]);
    endtask

    // One schedule: size only, or expected bits pushed LSB first
    task automatic sched(input int nch, input bit emit, inout int n, output int nb);
        int mk, w, a;
        mk = 0;
        nb = 0;
        for (int i = 0; i < nch; i++)
            if (dsc[i][27:24] > mk) mk = dsc[i][27:24];
        for (int s = 1; s <= (1 << mk); s++)
            for (int i = 0; i < nch; i++)
                if (s % (1 << dsc[i][27:24]) == 0) begin
                    w = wid(i);
                    a = (dsc[0][1:0] == MODE_PACKED) ? w : (w + 15) / 16 * 16;
                    nb += a;
                    if (emit) begin
                        if (dsc[0][1:0] == MODE_LSBPAD) put(64'h0, a - w);
                        put({53'h1f0f0f0f0f0f0f, 3'(i), 8'(n)}, w);
                        if (dsc[0][1:0] == MODE_MSBPAD) put(64'h0, a - w);
                        n++;
                    end
                end
    endtask

    // Whole packet: program, start, wait for idle, compare every word
    task automatic run(input int nch, input logic [15:0] ns, input logic [15:0] ml);
        int n, nb, cnt, nw, k;
        logic [15:0] wv;
        for (int i = 0; i < nch; i++) bus(1'b1, OFS_DESC + 6'(4 * i), dsc[i]);
        bus(1'b1, OFS_NSCHED, {16'h0, ns});
        bus(1'b1, OFS_MAXLEN, {16'h0, ml});
        eb.delete();
        u_rec.words.delete();
        n = ntk;
        sched(nch, 1'b0, n, nb);
        cnt = 1;
        while ((ns == 0 || cnt < ns) && 2 * nch + ((cnt + 1) * nb + 15) / 16 <= ml) cnt++;
        for (int i = 0; i < nch; i++) put(64'(dsc[i]), 32);
        for (int c = 0; c < cnt; c++) sched(nch, 1'b1, n, nb);
        while (eb.size() % 16 != 0) eb.push_back(1'b0);
        bus(1'b1, OFS_CTRL, (32'(nch - 1) << CTRL_NCH_LSB) | (32'h1 << CTRL_START_BIT));
        k = 0;
        while (busy !== 1'b1 && k < 10) begin
            @(posedge clk);
            k++;
        end
        if (busy !== 1'b1) tmo("busy rise");
        while (busy !== 1'b0 && k < 9000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 9000) tmo("busy fall");
        nw = eb.size() / 16;
        chk("word count", nw, u_rec.words.size());
        for (int j = 0; j < nw && j < u_rec.words.size(); j++) begin
            for (int b = 0; b < 16; b++) wv[b] = eb[16 * j + b];
            chk("word", {15'h0, j == nw - 1, wv}, 32'(u_rec.words[j]));
        end
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("schedules done", cnt, rd >> STAT_DONE_LSB);
    endtask

    // Main sequence
    initial begin
        resetn = 1'b0;
        slow = 1'b0;
        smp_valid = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_MAXLEN, 32'h0);
        chk("maxlen reset", {16'h0, RST_MAXLEN}, rd);
        bus(1'b0, OFS_NSCHED, 32'h0);
        chk("nsched reset", {16'h0, RST_NSCHED}, rd);
        bus(1'b0, OFS_DESC, 32'h0);
        chk("desc reset", RST_DESC, rd);
        bus(1'b0, 6'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        // MSB padding, mixed widths and rates, recorder stalling
        slow <= 1'b1;
        dsc[0] = 32'h01000033;
        dsc[1] = 32'h00000023;
        dsc[2] = 32'h02000033;
        run(3, 16'h0002, 16'hffff);
        // LSB padding on the same table
        slow <= 1'b0;
        for (int i = 0; i < 3; i++) dsc[i][1:0] = MODE_LSBPAD;
        run(3, 16'h0002, 16'hffff);
        // Packed: 12, 64 and 5 bit samples straddle words
        dsc[0] = 32'h00000030;
        dsc[1] = 32'h01000000;
        dsc[2] = 32'h00000014;
        run(3, 16'h0001, 16'hffff);
        // Length limit decides how many schedules fit
        dsc[0] = 32'h00000033;
        run(1, 16'h0000, 16'h0005);
        // Reserved mode is refused with the error flag
        u_rec.words.delete();
        bus(1'b1, OFS_DESC, 32'h00000032);
        bus(1'b1, OFS_CTRL, 32'h1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("reserved mode", 32'h2, rd & 32'h3);
        chk("reserved words", 32'h0, u_rec.words.size());
        test_done();
    end
endmodule // tb_top
`default_nettype wire
